// *** hw/external_irq_latch.sv ***
// External interrupt latch with AHB-Lite status/control registers
`timescale 1ns/1ps
module external_irq_latch
   import ext_irq_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic [2:0] i_hsize,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // External pin, active low
   input wire logic i_irq_pin_n,
   // CPU side
   input wire logic i_vector_fetch,
   input wire logic [15:0] i_vector_addr,
   input wire logic i_break_state,
   output logic o_irq_request,
   output logic o_pin_level,
   output logic [15:0] o_vector_base
);
   ahb_req_t req;
   ahb_phase_t phase_q, phase_d;
   vec_fetch_t vf;
   logic pin_level;
   logic pin_fall;
   logic latch_q, latch_d;
   logic mode_q, mode_d;
   logic mask_q, mask_d;
   logic break_clear_q, break_clear_d;
   logic [31:0] rdata_q, rdata_d;
   logic irq_q, irq_d;
   logic level_q, level_d;
   logic sw_ack;
   logic vec_ack;
   logic ack;
   logic pending;
   logic wr_status;
   logic wr_break;

   function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] offs);
      addr_hit = (a[7:2] == offs[7:2]);
   endfunction

   pin_sync u_pin_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_pin_n(i_irq_pin_n),
      .o_level(pin_level),
      .o_fall(pin_fall)
   );

   always_comb begin
      req.hsel = i_hsel;
      req.haddr = i_haddr;
      req.htrans = i_htrans;
      req.hsize = i_hsize;
      req.hwrite = i_hwrite;
      req.hready = i_hready;
      vf.fetch = i_vector_fetch;
      vf.addr = i_vector_addr;
   end

   // Bus address phase capture; slave is always ready
   always_comb begin
      phase_d.valid = req.hsel & req.hready & req.htrans[1];
      phase_d.write = req.hwrite;
      phase_d.addr = req.haddr;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         phase_q <= '0;
      end else begin
         phase_q <= phase_d;
      end
   end

   assign wr_status = phase_q.valid & phase_q.write & addr_hit(phase_q.addr, STATUS_CONTROL_OFFSET);
   assign wr_break = phase_q.valid & phase_q.write
      & addr_hit(phase_q.addr, BREAK_FLAG_CONTROL_OFFSET);

   // Break protection gates only the software path
   assign sw_ack = wr_status & i_hwdata[ACK_BIT] & (~i_break_state | break_clear_q);
   // Either vector byte fetch counts as the acknowledge
   assign vec_ack = vf.fetch & ((vf.addr == VECTOR_HIGH_ADDR) | (vf.addr == VECTOR_LOW_ADDR));
   assign ack = sw_ack | vec_ack;

   // Latch: edge set wins over a clear in the same cycle
   always_comb begin
      latch_d = latch_q;
      // Level mode keeps the request through the pin term, so any ack may clear the latch
      if (ack) begin
         latch_d = 1'b0;
      end
      if (pin_fall) begin
         latch_d = 1'b1;
      end
   end

   assign pending = latch_q | (mode_q & ~pin_level);

   // Control registers
   always_comb begin
      mode_d = mode_q;
      mask_d = mask_q;
      break_clear_d = break_clear_q;
      if (wr_status) begin
         mode_d = i_hwdata[MODE_BIT];
         mask_d = i_hwdata[MASK_BIT];
      end
      if (wr_break) begin
         break_clear_d = i_hwdata[BREAK_CLEAR_BIT];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         latch_q <= 1'b0;
         mode_q <= RESET_MODE;
         mask_q <= RESET_MASK;
         break_clear_q <= RESET_BREAK_CLEAR;
      end else begin
         latch_q <= latch_d;
         mode_q <= mode_d;
         mask_q <= mask_d;
         break_clear_q <= break_clear_d;
      end
   end

   // Read data, captured at the address phase for the next cycle
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (phase_d.valid & ~req.hwrite) begin
         if (addr_hit(req.haddr, STATUS_CONTROL_OFFSET)) begin
            rdata_d[MODE_BIT] = mode_d;
            rdata_d[MASK_BIT] = mask_d;
            rdata_d[ACK_BIT] = 1'b0;
            rdata_d[PEND_BIT] = latch_d | (mode_d & ~pin_level);
         end else if (addr_hit(req.haddr, BREAK_FLAG_CONTROL_OFFSET)) begin
            rdata_d[BREAK_CLEAR_BIT] = break_clear_d;
         end else if (addr_hit(req.haddr, VECTOR_OFFSET)) begin
            rdata_d[15:0] = VECTOR_HIGH_ADDR;
         end
      end
   end

   // Outputs to the CPU
   always_comb begin
      irq_d = latch_d | (mode_d & ~pin_level);
      irq_d = irq_d & ~mask_d;
      level_d = pin_level;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rdata_q <= 32'h0000_0000;
         irq_q <= 1'b0;
         level_q <= 1'b1;
      end else begin
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         level_q <= level_d;
      end
   end

   assign o_hrdata = rdata_q;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_irq_request = irq_q;
   assign o_pin_level = level_q;
   assign o_vector_base = VECTOR_HIGH_ADDR;
endmodule

// *** hw/pin_sync.sv ***
// Two-stage synchroniser with falling-edge detect for the interrupt pin
`timescale 1ns/1ps
module pin_sync
   import ext_irq_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Pin side
   input wire logic i_pin_n,
   // Synchronised outputs
   output logic o_level,
   output logic o_fall
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic prev_q, prev_d;
   logic [2:0] arm_q, arm_d;

   always_comb begin
      meta_d = i_pin_n;
      sync_d = meta_q;
      prev_d = sync_q;
      arm_d = {arm_q[1:0], 1'b1};
   end

   // Reset to high; a pin held low at release would look like an edge, but arm_q holds it off
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         prev_q <= 1'b1;
         arm_q <= 3'h0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
         arm_q <= arm_d;
      end
   end

   assign o_level = sync_q;
   // Edges held off until the chain holds real pin samples, else a pin low in reset fakes one
   assign o_fall = arm_q[2] & prev_q & ~sync_q;
endmodule

// *** inc/ext_irq_pkg.sv ***
// Package with register map, field positions and carrier types for the external interrupt block
package ext_irq_pkg;
   // Register byte offsets
   localparam logic [31:0] STATUS_CONTROL_OFFSET = 32'h0000_0000;
   localparam logic [31:0] BREAK_FLAG_CONTROL_OFFSET = 32'h0000_0004;
   localparam logic [31:0] VECTOR_OFFSET = 32'h0000_0008;
   // Status/control field positions
   localparam int MODE_BIT = 0;
   localparam int MASK_BIT = 1;
   localparam int ACK_BIT = 2;
   localparam int PEND_BIT = 3;
   // Break flag control field position
   localparam int BREAK_CLEAR_BIT = 7;
   // Values after reset
   localparam logic RESET_MODE = 1'b0;
   localparam logic RESET_MASK = 1'b0;
   localparam logic RESET_BREAK_CLEAR = 1'b0;
   // Vector locations
   localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hFFFA;
   localparam logic [15:0] VECTOR_LOW_ADDR = 16'hFFFB;
   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // AHB-Lite request bundle
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic [2:0] hsize;
      logic hwrite;
      logic hready;
   } ahb_req_t;

   // Captured address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } ahb_phase_t;

   // CPU vector fetch interface
   typedef struct packed {
      logic fetch;
      logic [15:0] addr;
   } vec_fetch_t;
endpackage

// *** tb/external_irq_latch_props.sv ***
// Port checker for the external interrupt latch
`timescale 1ns/1ps
module external_irq_latch_props
   import ext_irq_pkg::*;
(
   // Watched ports
   input wire logic i_sys_clk, i_rst, i_hsel, i_hwrite, i_hready, i_irq_pin_n,
   input wire logic [31:0] i_haddr, i_hwdata, o_hrdata,
   input wire logic [1:0] i_htrans,
   input wire logic i_vector_fetch, o_hreadyout, o_hresp, o_irq_request, o_pin_level,
   input wire logic [15:0] i_vector_addr, o_vector_base
);
   logic sel, wr_q, rd_q, md_q, msk_q;
   assign sel = i_hsel && i_hready && i_htrans[1] && i_haddr == STATUS_CONTROL_OFFSET;
   // Shadow of mode and mask, updated with the data phase
   always_ff @(posedge i_sys_clk) begin
      wr_q <= sel && i_hwrite;
      rd_q <= sel && !i_hwrite;
      md_q <= i_rst ? 1'b0 : wr_q ? i_hwdata[MODE_BIT] : md_q;
      msk_q <= i_rst ? 1'b0 : wr_q ? i_hwdata[MASK_BIT] : msk_q;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   AST_BUS: assert property (o_hreadyout && !o_hresp) else $error("bus answer");
   AST_VEC: assert property (o_vector_base == VECTOR_HIGH_ADDR) else $error("vector");
   AST_RST: assert property ($fell(i_rst) |-> !o_irq_request) else $error("reset");
   AST_HI: assert property (i_irq_pin_n [*4] |=> o_pin_level) else $error("pin high");
   AST_LO: assert property (!i_irq_pin_n [*4] |=> !o_pin_level) else $error("pin low");
   AST_MASK: assert property (msk_q |-> !o_irq_request) else $error("mask");
   AST_ACKRD: assert property (rd_q |-> o_hrdata[ACK_BIT] == 1'b0) else $error("ack");
   AST_FALL: assert property (($fell(i_irq_pin_n) && !msk_q && !wr_q) ##1
      (!i_irq_pin_n && !wr_q && !i_vector_fetch) [*4] |=> o_irq_request) else $error("fall");
   AST_FETCH: assert property (i_irq_pin_n [*4] ##0 (i_vector_fetch && !md_q &&
      i_vector_addr == VECTOR_HIGH_ADDR) ##1 i_irq_pin_n [*2] |=> !o_irq_request)
      else $error("fetch");
   AST_LEVEL: assert property ((md_q && !msk_q && !i_irq_pin_n) [*5] |=> o_irq_request)
      else $error("level");
endmodule

// *** tb/irq_source.sv ***
// Model of the external source on the active-low interrupt pin
`timescale 1ns/1ps
module irq_source (
   // Clock and command
   input wire logic i_sys_clk,
   input wire logic i_assert,
   // Pin, pulled high when released
   output logic o_pin_n = 1'b1
);
   // Released pin rises on its pull-up
   always @(posedge i_sys_clk) o_pin_n <= !i_assert;
endmodule

// *** tb/test_external_irq_latch.sv ***
// Self-checking bench for the external interrupt latch
`timescale 1ns/1ps
module test_external_irq_latch
   import ext_irq_pkg::*;
;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, fetch = 0, brk = 0, low = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0] htrans = 0;
   logic [15:0] vaddr = 0, vbase;
   logic rdy, resp, req, lvl, pin_n;
   int n_fail = 0, n_compared = 0;
   localparam logic [31:0] SC = STATUS_CONTROL_OFFSET;
   always #50 clk = ~clk;
   irq_source src_u (.i_sys_clk(clk), .i_assert(low), .o_pin_n(pin_n));
   external_irq_latch dut_u (.i_sys_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hsize(HSIZE_WORD), .i_hwrite(hwrite), .i_hready(rdy),
      .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp),
      .i_irq_pin_n(pin_n), .i_vector_fetch(fetch), .i_vector_addr(vaddr),
      .i_break_state(brk), .o_irq_request(req), .o_pin_level(lvl), .o_vector_base(vbase));
   task automatic complete_run;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic hold(input logic v, input int n);
      @(posedge clk);
      low <= v;
      cyc(n);
   endtask
   // CPU global mask sits outside the block; bench keeps it clear
   task automatic irq(input logic e, input string n);
      chk(n, {31'h0, e}, {31'h0, req});
   endtask
   // Address phase held until ready, then data phase until ready
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [31:0] a, e, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, e, q);
   endtask
   task automatic reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
   endtask
   task automatic t_edge;
      rd(SC, 32'h0, "status reset");
      rd(BREAK_FLAG_CONTROL_OFFSET, 32'h0, "break reset");
      rd(VECTOR_OFFSET, 32'h0000_FFFA, "vector");
      rd(32'h0000_0010, 32'h0, "unmapped");
      hold(1'b1, 6);
      chk("pin level", 32'h0, {31'h0, lvl});
      hold(1'b0, 6);
      irq(1'b1, "edge kept");
      bus(1'b1, SC, 32'h4);
      cyc(2);
      irq(1'b0, "sw ack");
      rd(SC, 32'h0, "ack reads zero");
      hold(1'b1, 6);
      irq(1'b1, "edge after ack");
      $display("edge test done");
   endtask
   task automatic t_mask;
      hold(1'b0, 2);
      bus(1'b1, SC, 32'h6);
      hold(1'b1, 6);
      irq(1'b0, "masked");
      rd(SC, 32'hA, "pending masked");
      hold(1'b0, 6);
      bus(1'b1, SC, 32'h0);
      @(posedge clk);
      fetch <= 1'b1;
      vaddr <= VECTOR_HIGH_ADDR;
      @(posedge clk);
      fetch <= 1'b0;
      cyc(2);
      irq(1'b0, "fetch ack");
      $display("mask test done");
   endtask
   task automatic t_level;
      bus(1'b1, SC, 32'h1);
      hold(1'b1, 6);
      bus(1'b1, SC, 32'h5);
      cyc(3);
      irq(1'b1, "level held");
      hold(1'b0, 6);
      irq(1'b0, "level released");
      bus(1'b1, SC, 32'h3);
      rd(SC, 32'h3, "level mode");
      $display("level test done");
   endtask
   task automatic t_break;
      bus(1'b1, SC, 32'h0);
      hold(1'b1, 6);
      hold(1'b0, 2);
      brk <= 1'b1;
      bus(1'b1, SC, 32'h4);
      rd(SC, 32'h8, "break protects");
      bus(1'b1, BREAK_FLAG_CONTROL_OFFSET, 32'h80);
      bus(1'b1, SC, 32'h4);
      brk <= 1'b0;
      rd(SC, 32'h0, "break cleared");
      bus(1'b1, SC, 32'h1);
      hold(1'b1, 6);
      reset;
      irq(1'b0, "reset clears");
      cyc(6);
      irq(1'b0, "reset pin low");
      rd(SC, 32'h0, "reset status");
      $display("break and reset test done");
   endtask
   initial begin
      reset;
      t_edge;
      t_mask;
      t_level;
      t_break;
      complete_run;
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      complete_run;
   end
endmodule
bind external_irq_latch external_irq_latch_props chk_u (.*);
